// File: hdl/fsr_regs.svh
`ifndef FSR_REGS_SVH
`define FSR_REGS_SVH

// Opcodes seen by the sequencer
`define FSR_OP_WR_ENABLE 8'h06
`define FSR_OP_RD_SR1 8'h05
`define FSR_OP_RD_SR2 8'h35
`define FSR_OP_RD_SR3 8'h15
`define FSR_OP_RD_EAR 8'hC8
`define FSR_OP_WR_EAR 8'hC5
`define FSR_OP_READ3 8'h03
`define FSR_OP_READ4 8'h13
`define FSR_OP_FAST3 8'h0B
`define FSR_OP_FAST4 8'h0C
`define FSR_OP_DIO3 8'hBB
`define FSR_OP_DIO4 8'hBC
`define FSR_OP_DOUT3 8'h3B
`define FSR_OP_DOUT4 8'h3C
`define FSR_OP_QIO3 8'hEB
`define FSR_OP_QIO4 8'hEC
`define FSR_OP_QOUT3 8'h6B
`define FSR_OP_QOUT4 8'h6C
`define FSR_OP_PROG3 8'h02
`define FSR_OP_PROG4 8'h12
`define FSR_OP_QPROG3 8'h32
`define FSR_OP_QPROG4 8'h34
`define FSR_OP_SUSPEND 8'h75
`define FSR_OP_RESUME 8'h7A
`define FSR_OP_RST_EN 8'h66
`define FSR_OP_RST 8'h99
`define FSR_OP_SEC_ERASE 8'h44

// Frame lengths in bits: opcode, opcode plus 3 or 4 address bytes
`define FSR_CNT_W 6
`define FSR_OP_BITS 6'h08
`define FSR_FRAME3_BITS 6'h20
`define FSR_FRAME4_BITS 6'h28
`define FSR_CNT_MAX 6'h3F

// Security register address fields
`define FSR_SA_TOP_MSB 23
`define FSR_SA_TOP_LSB 16
`define FSR_SA_SEL_MSB 15
`define FSR_SA_SEL_LSB 12
`define FSR_SA_ZERO_BIT 11
`define FSR_SA_SEL_FIRST 4'h1
`define FSR_SA_SEL_LAST 4'h3

// Suspend flag positions
`define FSR_SUS_ERASE 0
`define FSR_SUS_PROG 1

// Timing
`define FSR_CLK_NS 8
`define FSR_NS_PER_US 1000
`define FSR_T_RES_NS 200
`define FSR_SYNC_LAT 3
`define FSR_TMR_W 24

`endif

// File: hdl/fsr_pkg.sv
package fsr_pkg;

  // Suspend sequencer states, one-hot
  typedef enum logic [3:0] {
    FSR_RUN        = 4'h1,
    FSR_SUSPENDING = 4'h2,
    FSR_SUSPENDED  = 4'h4,
    FSR_RESUMING   = 4'h8
  } fsr_state_t;

endpackage

// File: hdl/fsr_core.sv
`include "fsr_regs.svh"


module fsr_core
  import fsr_pkg::*;
#(
  parameter int SUS_NS = 20000,
  parameter int SEC_ERASE_US = 100
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Serial pins
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_si,
  // Configuration from the status register
  input wire logic address_size_flag,
  input wire logic [2:0] security_lock_bits,
  // Array engine
  input wire logic engine_prog_busy,
  input wire logic engine_erase_busy,
  input wire logic engine_wel_clr,
  output logic engine_hold,
  // Status bits
  output logic write_in_progress,
  output logic [1:0] suspend_flags,
  output logic write_enable_latch,
  // Opcode filter result
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic cmd_allow,
  // Security register erase
  output logic sec_erase_busy,
  output logic [1:0] sec_erase_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counts

  localparam int SUS_CYC = (SUS_NS / `FSR_CLK_NS < 1) ? 1 : SUS_NS / `FSR_CLK_NS;
  localparam int RES_CYC = `FSR_T_RES_NS / `FSR_CLK_NS;
  // Pin synchroniser delay is taken out so busy returns in time from the pin
  localparam int RES_LOAD_I = RES_CYC - `FSR_SYNC_LAT - 1;
  localparam int SEC_CYC_I =
    (SEC_ERASE_US * `FSR_NS_PER_US + `FSR_CLK_NS - 1) / `FSR_CLK_NS;
  localparam logic [`FSR_TMR_W-1:0] SUS_LOAD = `FSR_TMR_W'(SUS_CYC);
  localparam logic [`FSR_TMR_W-1:0] RES_LOAD = `FSR_TMR_W'(RES_LOAD_I);
  localparam logic [`FSR_TMR_W-1:0] SEC_LOAD = `FSR_TMR_W'(SEC_CYC_I);
  localparam logic [`FSR_TMR_W-1:0] TMR_ONE = `FSR_TMR_W'(1);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Opcode filter for the current suspend and busy state
  function automatic logic op_allowed(input logic [7:0] op, input logic ps,
                                      input logic es, input logic sb);
    logic rd_sr;
    logic always_ok;
    logic es_only;
    begin
      rd_sr = (op == `FSR_OP_RD_SR1) || (op == `FSR_OP_RD_SR2) ||
              (op == `FSR_OP_RD_SR3);
      always_ok = rd_sr ||
        (op == `FSR_OP_RD_EAR) || (op == `FSR_OP_WR_EAR) ||
        (op == `FSR_OP_READ3) || (op == `FSR_OP_READ4) ||
        (op == `FSR_OP_FAST3) || (op == `FSR_OP_FAST4) ||
        (op == `FSR_OP_DIO3) || (op == `FSR_OP_DIO4) ||
        (op == `FSR_OP_DOUT3) || (op == `FSR_OP_DOUT4) ||
        (op == `FSR_OP_QIO3) || (op == `FSR_OP_QIO4) ||
        (op == `FSR_OP_QOUT3) || (op == `FSR_OP_QOUT4) ||
        (op == `FSR_OP_RESUME) || (op == `FSR_OP_RST_EN) ||
        (op == `FSR_OP_RST);
      es_only = (op == `FSR_OP_WR_ENABLE) ||
        (op == `FSR_OP_PROG3) || (op == `FSR_OP_PROG4) ||
        (op == `FSR_OP_QPROG3) || (op == `FSR_OP_QPROG4);
      if (sb)
        op_allowed = rd_sr;
      else if (!(ps || es))
        op_allowed = 1'b1;
      else
        // Anything not listed, erases and status writes among them, is refused
        op_allowed = always_ok || (es_only && es && !ps);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [1:0] cs_sync_q;
  logic [1:0] sck_sync_q;
  logic [1:0] si_sync_q;
  logic cs_prev_q;
  logic sck_prev_q;
  logic cs_rise;
  logic sck_rise;

  // Two flops per pin; only the second stage feeds logic
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cs_sync_q <= 2'h3;
      sck_sync_q <= 2'h0;
      si_sync_q <= 2'h0;
      cs_prev_q <= 1'b1;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      cs_sync_q <= {cs_sync_q[0], spi_cs_n};
      sck_sync_q <= {sck_sync_q[0], spi_sclk};
      si_sync_q <= {si_sync_q[0], spi_si};
      cs_prev_q <= cs_sync_q[1];
      sck_prev_q <= sck_sync_q[1];
    end
  end

  // Edges of the synchronised pins
  assign cs_rise = cs_sync_q[1] && !cs_prev_q;
  assign sck_rise = sck_sync_q[1] && !sck_prev_q && !cs_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Frame capture

  logic [`FSR_CNT_W-1:0] bit_cnt_q;
  logic [7:0] op_q;
  logic [31:0] addr_q;
  logic [7:0] op_now;
  logic op_done;

  // Opcode as it completes on the eighth rising clock
  assign op_now = {op_q[6:0], si_sync_q[1]};
  assign op_done = sck_rise && (bit_cnt_q == `FSR_OP_BITS - 6'h01);

  // Bits after the opcode shift into the address register
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bit_cnt_q <= '0;
      op_q <= 8'h00;
      addr_q <= 32'h0000_0000;
    end
    else if (cs_sync_q[1])
      bit_cnt_q <= '0;
    else if (sck_rise)
    begin
      // Counter saturates so an overlong frame never matches a length
      if (bit_cnt_q != `FSR_CNT_MAX)
        bit_cnt_q <= bit_cnt_q + 6'h01;
      if (bit_cnt_q < `FSR_OP_BITS)
        op_q <= op_now;
      else
        addr_q <= {addr_q[30:0], si_sync_q[1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame end decode

  fsr_state_t st_q;
  logic wip_q;
  logic [1:0] sus_q;
  logic wel_q;
  logic hold_q;
  logic sec_busy_q;
  logic [`FSR_TMR_W-1:0] sec_tmr_q;
  logic [1:0] sec_sel_q;
  logic [`FSR_TMR_W-1:0] sus_tmr_q;
  logic [`FSR_CNT_W-1:0] frame_bits;
  logic [3:0] sa_sel;
  logic sa_valid;
  logic sa_locked;
  logic bare_frame;
  logic sus_req;
  logic res_req;
  logic wen_req;
  logic se_req;
  logic se_ok;

  // Frame length for the address width in force
  assign frame_bits = address_size_flag ? `FSR_FRAME4_BITS : `FSR_FRAME3_BITS;

  // Security register select and lock check
  assign sa_sel = addr_q[`FSR_SA_SEL_MSB:`FSR_SA_SEL_LSB];
  assign sa_valid = (addr_q[`FSR_SA_TOP_MSB:`FSR_SA_TOP_LSB] == 8'h00) &&
                    !addr_q[`FSR_SA_ZERO_BIT] && (sa_sel >= `FSR_SA_SEL_FIRST) &&
                    (sa_sel <= `FSR_SA_SEL_LAST);
  assign sa_locked = security_lock_bits[2'(sa_sel - `FSR_SA_SEL_FIRST)];

  // Requests are judged only when chip select rises
  assign bare_frame = cs_rise && (bit_cnt_q == `FSR_OP_BITS);
  assign sus_req = bare_frame && (op_q == `FSR_OP_SUSPEND);
  assign res_req = bare_frame && (op_q == `FSR_OP_RESUME);
  assign wen_req = bare_frame && (op_q == `FSR_OP_WR_ENABLE) &&
                   op_allowed(op_q, sus_q[`FSR_SUS_PROG], sus_q[`FSR_SUS_ERASE],
                              sec_busy_q);
  assign se_req = cs_rise && (op_q == `FSR_OP_SEC_ERASE) &&
                  (bit_cnt_q == frame_bits);
  // Refused during any suspend and while anything is busy
  assign se_ok = se_req && wel_q && !wip_q && (sus_q == 2'h0) && !sec_busy_q &&
                 sa_valid && !sa_locked;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode filter output

  // Published once per frame, on the eighth clock
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmd_valid <= 1'b0;
      cmd_code <= 8'h00;
      cmd_allow <= 1'b0;
    end
    else
    begin
      cmd_valid <= op_done;
      if (op_done)
      begin
        cmd_code <= op_now;
        cmd_allow <= op_allowed(op_now, sus_q[`FSR_SUS_PROG], sus_q[`FSR_SUS_ERASE],
                                sec_busy_q);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Suspend and resume sequencer

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= FSR_RUN;
      sus_q <= 2'h0;
      hold_q <= 1'b0;
      sus_tmr_q <= '0;
    end
    else
    begin
      case (st_q)
        FSR_RUN:
        begin
          // Only a running page program or sector/block erase may pause
          if (sus_req && (sus_q == 2'h0) && wip_q && !sec_busy_q &&
              (engine_prog_busy || engine_erase_busy))
          begin
            st_q <= FSR_SUSPENDING;
            sus_q[`FSR_SUS_PROG] <= engine_prog_busy;
            sus_q[`FSR_SUS_ERASE] <= !engine_prog_busy;
            hold_q <= 1'b1;
            sus_tmr_q <= SUS_LOAD;
          end
        end
        FSR_SUSPENDING:
        begin
          if (sus_tmr_q <= TMR_ONE)
            st_q <= FSR_SUSPENDED;
          else
            sus_tmr_q <= sus_tmr_q - TMR_ONE;
        end
        FSR_SUSPENDED:
        begin
          // A program started inside erase suspend keeps busy high and blocks resume
          if (res_req && !wip_q)
          begin
            st_q <= FSR_RESUMING;
            sus_q <= 2'h0;
            hold_q <= 1'b0;
            sus_tmr_q <= RES_LOAD;
          end
        end
        FSR_RESUMING:
        begin
          if (sus_tmr_q <= TMR_ONE)
            st_q <= FSR_RUN;
          else
            sus_tmr_q <= sus_tmr_q - TMR_ONE;
        end
        default:
        begin
          st_q <= FSR_RUN;
          sus_q <= 2'h0;
          hold_q <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write in progress

  // Busy follows the sequencer: held through suspend latency, low once paused unless a program runs inside erase suspend
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      wip_q <= 1'b0;
    else
    begin
      case (st_q)
        FSR_RUN: wip_q <= engine_prog_busy || engine_erase_busy || sec_busy_q;
        FSR_SUSPENDING: wip_q <= 1'b1;
        FSR_SUSPENDED: wip_q <= sus_q[`FSR_SUS_ERASE] && engine_prog_busy;
        FSR_RESUMING: wip_q <= 1'b0;
        default: wip_q <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write enable latch

  // A set in the same cycle as an engine clear wins
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      wel_q <= 1'b0;
    else if (wen_req)
      wel_q <= 1'b1;
    else if (se_ok || engine_wel_clr)
      wel_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Security register erase timer

  // Self-timed; the array side erases the selected register while busy
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sec_busy_q <= 1'b0;
      sec_tmr_q <= '0;
      sec_sel_q <= 2'h0;
    end
    else if (se_ok)
    begin
      sec_busy_q <= 1'b1;
      sec_tmr_q <= SEC_LOAD;
      sec_sel_q <= sa_sel[1:0];
    end
    else if (sec_busy_q)
    begin
      if (sec_tmr_q <= TMR_ONE)
        sec_busy_q <= 1'b0;
      else
        sec_tmr_q <= sec_tmr_q - TMR_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flop

  assign engine_hold = hold_q;
  assign write_in_progress = wip_q;
  assign suspend_flags = sus_q;
  assign write_enable_latch = wel_q;
  assign sec_erase_busy = sec_busy_q;
  assign sec_erase_sel = sec_sel_q;

endmodule

// File: dv/fsr_host.sv
module fsr_host
(
  // Serial pins toward the device
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_si
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle: deselected, link clock parked low
  initial
  begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_si = 1'b0;
  end

  // Whole frame MSB first; off-grid start keeps edges clear of the system clock
  task automatic frame(input logic [39:0] d, input int n);
    #0.1;
    spi_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      spi_si = d[i];
      #62.5 spi_sclk = 1'b1;
      #62.5 spi_sclk = 1'b0;
    end
    #62.5 spi_cs_n = 1'b1;
    // Released line shows the inverse, never a stale copy
    spi_si = ~spi_si;
    #62.5;
  endtask
endmodule

// File: dv/fsr_core_properties.sv
module fsr_core_props
#(
  parameter int SUS_NS = 20000,
  parameter int SEC_ERASE_US = 100
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Serial pins
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_si,
  // Configuration
  input wire logic address_size_flag,
  input wire logic [2:0] security_lock_bits,
  // Array engine
  input wire logic engine_prog_busy,
  input wire logic engine_erase_busy,
  input wire logic engine_wel_clr,
  input wire logic engine_hold,
  // Status and filter
  input wire logic write_in_progress,
  input wire logic [1:0] suspend_flags,
  input wire logic write_enable_latch,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_allow,
  input wire logic sec_erase_busy,
  input wire logic [1:0] sec_erase_sel
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////
  // Suspend entry and exit steps
  sequence sus_begin;
    $rose(|suspend_flags);
  endsequence
  sequence sus_end;
    $fell(|suspend_flags);
  endsequence

  // Suspend only lands on a busy operation of the matching kind
  a_sus_gate: assert property (sus_begin |-> write_in_progress && !sec_erase_busy &&
    (suspend_flags[1] ? engine_prog_busy : engine_erase_busy)) else $error("bad suspend");
  // Flags first, busy drops only later
  a_sus_wip_lags: assert property (sus_begin |-> write_in_progress [*4])
    else $error("busy dropped with flags");
  a_sus_sticky: assert property ((|suspend_flags) [*2] |-> suspend_flags == $past(suspend_flags))
    else $error("flags changed while suspended");
  a_hold_follows: assert property (engine_hold == (|suspend_flags))
    else $error("hold not tied to flags");
  a_res_gate: assert property (sus_end |-> $past(write_in_progress) == 1'b0)
    else $error("resume while busy");
  // 200 ns is 25 cycles
  a_res_wip: assert property (sus_end |-> ##[1:25] write_in_progress)
    else $error("busy late after resume");

  ////////////////////////////////////////////////////////////////
  // Security register erase
  a_sec_wel: assert property ($rose(sec_erase_busy) |-> $past(write_enable_latch) &&
    !write_enable_latch) else $error("erase without latch");
  a_sec_lock: assert property ($rose(sec_erase_busy) |-> sec_erase_sel != 2'h0 &&
    !security_lock_bits[sec_erase_sel - 2'h1]) else $error("locked register erased");
  a_sec_wip: assert property (sec_erase_busy [*2] |-> write_in_progress)
    else $error("erase not busy");
  a_sec_done: assert property ($fell(sec_erase_busy) && !engine_prog_busy &&
    !engine_erase_busy |=> !write_in_progress) else $error("busy after erase");

  ////////////////////////////////////////////////////////////////
  // Opcode filter while suspended or erasing
  a_flt_keep: assert property (cmd_valid && (|suspend_flags) && cmd_code inside {8'h05,
    8'h35, 8'h15, 8'hC8, 8'hC5, 8'h03, 8'h0B, 8'hEB, 8'h3C} |=> cmd_allow) else $error("read refused");
  a_flt_block: assert property (cmd_valid && (|suspend_flags) && cmd_code inside {8'h01,
    8'h31, 8'h11, 8'h44, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60} |=> !cmd_allow) else $error("write let in");
  a_flt_prog: assert property (cmd_valid && suspend_flags[1] && cmd_code inside {8'h06,
    8'h02, 8'h32, 8'h42} |=> !cmd_allow) else $error("program in program suspend");
  a_flt_poll: assert property (cmd_valid && sec_erase_busy && cmd_code inside {8'h05,
    8'h35, 8'h15} |=> cmd_allow) else $error("poll refused");
endmodule

bind fsr_core fsr_core_props #(.SUS_NS(SUS_NS), .SEC_ERASE_US(SEC_ERASE_US)) i_props (.clk_sys,
  .arst_n, .spi_cs_n, .spi_sclk, .spi_si, .address_size_flag, .security_lock_bits,
  .engine_prog_busy, .engine_erase_busy, .engine_wel_clr, .engine_hold, .write_in_progress,
  .suspend_flags, .write_enable_latch, .cmd_valid, .cmd_code, .cmd_allow, .sec_erase_busy,
  .sec_erase_sel);

// File: dv/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys, arst_n, address_size_flag, engine_prog_busy, engine_erase_busy;
  logic engine_wel_clr, spi_cs_n, spi_sclk, spi_si, engine_hold, write_in_progress;
  logic write_enable_latch, cmd_valid, cmd_allow, sec_erase_busy;
  logic [2:0] security_lock_bits;
  logic [1:0] suspend_flags, sec_erase_sel;
  logic [7:0] cmd_code;
  int mismatches = 0;
  int n_checks = 0;
  int n_valid = 0;
  // Every opcode class the filter sorts; resume and reset left out
  logic [7:0] ops [32] = '{8'h05, 8'h35, 8'h15, 8'hC8, 8'hC5, 8'h03, 8'h13, 8'h0B, 8'h0C,
    8'hBB, 8'hBC, 8'h3B, 8'h3C, 8'hEB, 8'hEC, 8'h6B, 8'h6C, 8'h06, 8'h02, 8'h12, 8'h32,
    8'h34, 8'h01, 8'h31, 8'h11, 8'h44, 8'h42, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};

  // Short latencies: 25 cycles to suspend, 500 cycles of erase
  fsr_core #(.SUS_NS(200), .SEC_ERASE_US(4)) i_dut (.clk_sys, .arst_n, .spi_cs_n, .spi_sclk,
    .spi_si, .address_size_flag, .security_lock_bits, .engine_prog_busy, .engine_erase_busy,
    .engine_wel_clr, .engine_hold, .write_in_progress, .suspend_flags, .write_enable_latch,
    .cmd_valid, .cmd_code, .cmd_allow, .sec_erase_busy, .sec_erase_sel);
  fsr_host i_host (.spi_cs_n, .spi_sclk, .spi_si);

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Filter pulses, counted at the edge after they appear
  always @(posedge clk_sys)
    if (cmd_valid === 1'b1)
      n_valid++;

  ////////////////////////////////////////////////////////////////
  // Inputs move 1 ns after the edge, away from sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic send(input logic [39:0] d, input int n);
    i_host.frame(d, n);
    cyc(2);
  endtask
  // Bounded wait, so a stuck bit cannot hang the run
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    for (int t = 0; t < lim && s !== v; t++)
      cyc(1);
  endtask
  // Mode 0 running, 1 erase suspended, 2 program suspended, 3 erasing
  function automatic logic exp_allow(input logic [7:0] op, input int mode);
    logic ok;
    ok = op inside {8'h05, 8'h35, 8'h15};
    if (mode == 3)
      return ok;
    ok = ok || op inside {8'hC8, 8'hC5, 8'h03, 8'h13, 8'h0B, 8'h0C, 8'hBB, 8'hBC, 8'h3B,
      8'h3C, 8'hEB, 8'hEC, 8'h6B, 8'h6C};
    if (mode == 1)
      ok = ok || op inside {8'h06, 8'h02, 8'h12, 8'h32, 8'h34};
    return (mode == 0) ? 1'b1 : ok;
  endfunction
  task automatic probe(input logic [7:0] op, input logic ok);
    int v0;
    v0 = n_valid;
    send({32'h0, op}, 8);
    chk(cmd_code, op, "code");
    chk(8'(cmd_allow), 8'(ok), "allow");
    // Exactly one filter pulse per opcode frame
    chk(8'(n_valid - v0), 8'h01, "one valid pulse");
  endtask
  task automatic test_done();
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [1:0] sel;
    logic [2:0] lk;
    logic [23:0] a;
    logic [7:0] op;
    void'($urandom(62514));
    arst_n = 1'b0;
    address_size_flag = 1'b0;
    security_lock_bits = 3'h0;
    engine_prog_busy = 1'b0;
    engine_erase_busy = 1'b0;
    engine_wel_clr = 1'b0;
    cyc(2);
    arst_n = 1'b1;
    cyc(2);
    send(40'h75, 8);
    chk(8'(suspend_flags), 8'h00, "idle suspend");
    send(40'h7A, 8);
    chk(8'({suspend_flags, write_in_progress}), 8'h00, "idle resume");
    // Outside any suspend or security erase the filter lets everything through
    op = ops[$urandom_range(31)];
    probe(op, exp_allow(op, 0));
    // k = 1 erase, k = 2 program, matching the flag bit
    for (int k = 1; k <= 2; k++)
    begin
      engine_erase_busy = (k == 1);
      engine_prog_busy = (k == 2);
      cyc(2);
      send(40'h75, 8);
      chk(8'(suspend_flags), 8'(k), "flags");
      chk(8'({engine_hold, write_in_progress}), 8'h03, "hold");
      wait_lvl(write_in_progress, 1'b0, 40);
      chk(8'(write_in_progress), 8'h00, "paused");
      send(40'h75, 8);
      chk(8'(suspend_flags), 8'(k), "again");
      for (int i = 0; i < 40; i++)
      begin
        op = (i < 32) ? ops[i] : ops[$urandom_range(31)];
        probe(op, exp_allow(op, k));
      end
      send(40'h7A, 8);
      chk(8'({suspend_flags, engine_hold}), 8'h00, "resume");
      wait_lvl(write_in_progress, 1'b1, 25);
      chk(8'(write_in_progress), 8'h01, "resumed");
      engine_erase_busy = 1'b0;
      engine_prog_busy = 1'b0;
    end
    // j: 0 locked, 1 one bit too many, 2 three-byte, 3 four-byte
    for (int j = 0; j < 4; j++)
    begin
      sel = 2'($urandom_range(3, 1));
      a = {8'h00, 2'h0, sel, 1'h0, 11'($urandom)};
      lk = 3'h1 << (sel - 2'h1);
      security_lock_bits = (j == 0) ? lk : ~lk;
      address_size_flag = (j == 3);
      send(40'h06, 8);
      chk(8'(write_enable_latch), 8'h01, "wel");
      if (j == 1)
        send({7'h00, 8'h44, a, 1'h0}, 33);
      else if (j == 3)
        send({8'h44, 8'h00, a}, 40);
      else
        send({8'h00, 8'h44, a}, 32);
      chk(8'(sec_erase_busy), 8'(j >= 2), "start");
      if (j >= 2)
      begin
        chk(8'({write_in_progress, write_enable_latch, sel}), 8'({2'h2, sel}), "run");
        chk(8'(sec_erase_sel), 8'(sel), "sel");
        probe(8'h05, exp_allow(8'h05, 3));
        probe(8'h03, exp_allow(8'h03, 3));
        // Two probes take far less than the 500-cycle erase
        chk(8'(sec_erase_busy), 8'h01, "still erasing");
        wait_lvl(sec_erase_busy, 1'b0, 600);
        // Busy status trails the erase timer by one cycle
        cyc(1);
        chk(8'({sec_erase_busy, write_in_progress}), 8'h00, "done");
      end
    end
    // Engine clear drops the latch
    send(40'h06, 8);
    chk(8'(write_enable_latch), 8'h01, "wel again");
    engine_wel_clr = 1'b1;
    cyc(1);
    engine_wel_clr = 1'b0;
    cyc(1);
    chk(8'(write_enable_latch), 8'h00, "engine clear");
    test_done();
  end

  // About 17k cycles expected; give up after 75k
  initial
  begin
    #600000;
    mismatches++;
    test_done();
  end
endmodule
